/* File: verilog/dmacar_pkg.sv */
package dmacar_pkg;
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int ADDR_W = 16;
  localparam int CNT_W = 10;
  localparam int REG_W = 16;
  localparam int PADDR_W = 12;
  // per channel block of four words
  localparam logic [PADDR_W-1:0] CH_STRIDE = 12'h010;
  localparam logic [PADDR_W-1:0] OFS_PERIPH_ADDR = 12'h000;
  localparam logic [PADDR_W-1:0] OFS_XFER_COUNT = 12'h004;
  localparam logic [PADDR_W-1:0] OFS_CTRL = 12'h008;
  localparam logic [PADDR_W-1:0] OFS_STATUS = 12'h00C;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_REM_LSB = 16;
  localparam logic [ADDR_W-1:0] PERIPH_ADDR_RST = 16'h0000;
  localparam logic [CNT_W-1:0] XFER_COUNT_RST = 10'h000;
  typedef enum logic [1:0] {
    DMACAR_IDLE,
    DMACAR_RUN,
    DMACAR_DONE
  } dmacar_state_t;
endpackage

/* File: verilog/dmacar_apb_slave.sv */
`timescale 1ns/10ps
// single-cycle apb slave: decodes channel and word
module dmacar_apb_slave
  import dmacar_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dmacar_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] rdData,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wrStb,
  output logic [dmacar_pkg::CH_W-1:0] chSel,
  output logic [dmacar_pkg::PADDR_W-1:0] wordOfs,
  output logic mapped
);
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic pready_ff;
  logic access;

  assign access = psel & penable;
  assign chSel = paddr[CH_W+3:4];
  assign wordOfs = paddr & (CH_STRIDE - 12'h001);
  // unmapped beyond the last channel, or misaligned
  assign mapped = (paddr < PADDR_W'(NUM_CH * 16)) && (paddr[1:0] == 2'h0);
  assign wrStb = access & pwrite & mapped;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    // flagged from setup so it stands through the access phase
    nxt_pslverr = psel & ~penable & ~mapped;
    if (psel & ~penable & ~pwrite & mapped) begin
      nxt_prdata = rdData;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
      pready_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      pready_ff <= 1'b1;
    end
  end
endmodule // dmacar_apb_slave

/* File: verilog/dmacar_channel.sv */
`timescale 1ns/10ps
// one channel's run engine
module dmacar_channel
  import dmacar_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic [dmacar_pkg::ADDR_W-1:0] periphAddr,
  input wire logic [dmacar_pkg::CNT_W-1:0] xferCount,
  input wire logic xferAck,
  output logic xferReq,
  output logic [dmacar_pkg::ADDR_W-1:0] xferAddr,
  output logic busy,
  output logic done,
  output logic [dmacar_pkg::CNT_W:0] remaining
);
  dmacar_state_t state_ff, nxt_state;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [CNT_W:0] rem_ff, nxt_rem;

  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_rem = rem_ff;
    unique case (state_ff)
      DMACAR_IDLE, DMACAR_DONE: begin
        if (enable && state_ff == DMACAR_IDLE) begin
          nxt_addr = periphAddr;
          nxt_rem = {1'b0, xferCount} + 11'h001;
          nxt_state = DMACAR_RUN;
        end else if (!enable) begin
          nxt_state = DMACAR_IDLE;
        end
      end
      DMACAR_RUN: begin
        if (!enable) begin
          nxt_state = DMACAR_IDLE;
          nxt_rem = '0;
        end else if (xferAck) begin
          nxt_rem = rem_ff - 11'h001;
          // stop after the last one; re-enable needed to rerun
          if (rem_ff == 11'h001) begin
            nxt_state = DMACAR_DONE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= DMACAR_IDLE;
      addr_ff <= PERIPH_ADDR_RST;
      rem_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      rem_ff <= nxt_rem;
    end
  end

  assign xferReq = (state_ff == DMACAR_RUN);
  assign xferAddr = addr_ff;
  assign busy = (state_ff == DMACAR_RUN);
  assign done = (state_ff == DMACAR_DONE);
  assign remaining = rem_ff;
endmodule // dmacar_channel

/* File: verilog/dmacar_top.sv */
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
module dmacar_top
  import dmacar_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dmacar_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic [dmacar_pkg::NUM_CH-1:0] xferAck,
  output logic [dmacar_pkg::NUM_CH-1:0] xferReq_ff,
  output logic [dmacar_pkg::NUM_CH*dmacar_pkg::ADDR_W-1:0] xferAddr_ff,
  output logic [dmacar_pkg::NUM_CH-1:0] chDone_ff
);
  logic [ADDR_W-1:0] periphAddr_ff [NUM_CH];
  logic [ADDR_W-1:0] nxt_periphAddr [NUM_CH];
  logic [CNT_W-1:0] xferCount_ff [NUM_CH];
  logic [CNT_W-1:0] nxt_xferCount [NUM_CH];
  logic [NUM_CH-1:0] enable_ff, nxt_enable;
  logic [NUM_CH-1:0] chReq, chBusy, chDone;
  logic [ADDR_W-1:0] chAddr [NUM_CH];
  logic [CNT_W:0] chRem [NUM_CH];
  logic wrStb, mapped;
  logic [CH_W-1:0] chSel;
  logic [PADDR_W-1:0] wordOfs;
  logic [31:0] rdData;

  dmacar_apb_slave u_apb (
    .clock(clock),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .rdData(rdData),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wrStb(wrStb),
    .chSel(chSel),
    .wordOfs(wordOfs),
    .mapped(mapped)
  );

  // register writes; pready is always high so strobe is the write edge
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      nxt_periphAddr[i] = periphAddr_ff[i];
      nxt_xferCount[i] = xferCount_ff[i];
      nxt_enable[i] = enable_ff[i];
      // channel clears its own enable when the block completes
      if (chDone[i]) begin
        nxt_enable[i] = 1'b0;
      end
    end
    if (wrStb) begin
      unique case (wordOfs)
        OFS_PERIPH_ADDR: nxt_periphAddr[chSel] = pwdata[ADDR_W-1:0];
        // bits 15-10 are dropped here
        OFS_XFER_COUNT: nxt_xferCount[chSel] = pwdata[CNT_W-1:0];
        OFS_CTRL: nxt_enable[chSel] = pwdata[CTRL_EN_BIT];
        default: ;
      endcase
    end
  end

  always_comb begin
    rdData = 32'h0000_0000;
    unique case (wordOfs)
      OFS_PERIPH_ADDR: rdData[ADDR_W-1:0] = periphAddr_ff[chSel];
      // upper count bits stay zero
      OFS_XFER_COUNT: rdData[CNT_W-1:0] = xferCount_ff[chSel];
      OFS_CTRL: rdData[CTRL_EN_BIT] = enable_ff[chSel];
      OFS_STATUS: begin
        rdData[STAT_BUSY_BIT] = chBusy[chSel];
        rdData[STAT_DONE_BIT] = chDone[chSel];
        rdData[STAT_REM_LSB +: CNT_W+1] = chRem[chSel];
      end
      default: ;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        periphAddr_ff[i] <= PERIPH_ADDR_RST;
        xferCount_ff[i] <= XFER_COUNT_RST;
      end
      enable_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        // writes while enabled are accepted; results are unspecified
        periphAddr_ff[i] <= nxt_periphAddr[i];
        xferCount_ff[i] <= nxt_xferCount[i];
      end
      enable_ff <= nxt_enable;
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    dmacar_channel u_ch (
      .clock(clock),
      .rst_b(rst_b),
      .enable(enable_ff[g]),
      .periphAddr(periphAddr_ff[g]),
      .xferCount(xferCount_ff[g]),
      .xferAck(xferAck[g] & xferReq_ff[g]),
      .xferReq(chReq[g]),
      .xferAddr(chAddr[g]),
      .busy(chBusy[g]),
      .done(chDone[g]),
      .remaining(chRem[g])
    );
  end

  // outputs registered; req drops the cycle after the last ack
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      xferReq_ff <= '0;
      xferAddr_ff <= '0;
      chDone_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        xferReq_ff[i] <= chReq[i] & ~(xferAck[i] & xferReq_ff[i]
          & (chRem[i] == 11'h001));
        xferAddr_ff[i*ADDR_W +: ADDR_W] <= chAddr[i];
        chDone_ff[i] <= chDone[i];
      end
    end
  end
endmodule // dmacar_top

/* File: dv/dmacar_chk.sv */
`timescale 1ns/10ps
module dmacar_chk
  import dmacar_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [3:0] xferAck,
  input wire logic [3:0] xferReq_ff,
  input wire logic [63:0] xferAddr_ff,
  input wire logic [3:0] chDone_ff
);
  logic [10:0] tgt_ff, nxt_tgt, acks_ff, nxt_acks;
  wire logic acc = psel && penable;
  always_comb begin
    nxt_tgt = tgt_ff;
    nxt_acks = acks_ff + 11'(xferAck[0] && xferReq_ff[0]);
    if (acc && pwrite && paddr == 12'h004)
      nxt_tgt = {1'b0, pwdata[9:0]} + 11'h001;
    // restart the tally at each channel 0 start
    if (acc && pwrite && paddr == 12'h008)
      nxt_acks = 11'h000;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tgt_ff <= 11'h001;
      acks_ff <= 11'h000;
    end else begin
      tgt_ff <= nxt_tgt;
      acks_ff <= nxt_acks;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence sEnWr;
    acc && pwrite && paddr == 12'h008 && pwdata[0];
  endsequence
  sequence sRd(logic [3:0] o);
    acc && !pwrite && paddr[3:0] == o && paddr < 12'h040;
  endsequence
  chk_start_delay: assert property (sEnWr |-> ##3 xferReq_ff[0])
    else $error("channel start late");
  chk_count_upper: assert property (sRd(4'h4) |-> prdata[31:10] == 0)
    else $error("count upper bits set");
  chk_addr_width: assert property (sRd(4'h0) |-> prdata[31:16] == 0)
    else $error("address upper bits set");
  chk_ack_total: assert property ($fell(xferReq_ff[0]) |-> acks_ff == tgt_ff)
    else $error("wrong transfer total");
  chk_done_follow: assert property ($fell(xferReq_ff[0]) |-> ##[0:2] chDone_ff[0])
    else $error("done missing");
  chk_addr_hold: assert property (xferReq_ff[0] && $past(xferReq_ff[0])
    |-> $stable(xferAddr_ff[15:0]))
    else $error("address moved in run");
endmodule // dmacar_chk
bind dmacar_top dmacar_chk i_dmacar_chk (.clock(clock), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .xferAck(xferAck),
  .xferReq_ff(xferReq_ff), .xferAddr_ff(xferAddr_ff), .chDone_ff(chDone_ff));

/* File: dv/test_dma_channel_addr_count_regs.sv */
`timescale 1ns/10ps
module test_dma_channel_addr_count_regs;
  import dmacar_pkg::*;
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, b;
  logic [31:0] pwdata, prdata, rnd, w;
  logic [3:0] xferAck, xferReq_ff, chDone_ff;
  logic [63:0] xferAddr_ff;
  logic [31:0] expQ[$];
  int errors, checks_done, c;
  dmacar_top i_dmacar_top (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .xferAck(xferAck),
    .xferReq_ff(xferReq_ff), .xferAddr_ff(xferAddr_ff), .chDone_ff(chDone_ff));
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      errors++;
      tally_and_finish;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // acks arrive at random, also while the request is low
  task automatic runCh(input logic [11:0] a0, input logic [9:0] n);
    int got, k;
    logic [15:0] a;
    a = rnd[31:16];
    apb(1'b1, a0, {16'hFFFF, a});
    apb(1'b1, a0 + 12'h004, {22'h0, n});
    apb(1'b1, a0 + 12'h008, 32'h1);
    got = 0;
    for (k = 0; k < 3000 && chDone_ff[a0[5:4]] !== 1'b1; k++) begin
      rnd = lf(rnd);
      xferAck <= rnd[3:0];
      @(posedge clock);
      if (xferReq_ff[a0[5:4]] === 1'b1) begin
        check(xferAddr_ff[a0[5:4]*16+:16], a, "xferAddr");
        got += xferAck[a0[5:4]];
      end
    end
    xferAck <= 4'h0;
    if (k == 3000) begin
      errors++;
      tally_and_finish;
    end
    check(got, {22'h0, n} + 1, "transfers");
    rd(a0 + 12'h008, 32'h0);
    rd(a0 + 12'h00C, 32'h0);
  endtask
  always @(posedge clock) begin
    if (psel && penable && !pwrite && pready)
      check(prdata, expQ.pop_front(), "prdata");
    if (psel && penable && pready)
      check({31'h0, pslverr},
        {31'h0, (paddr >= 12'h040) || (paddr[1:0] != 2'h0)}, "pslverr");
  end
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, xferAck} = '0;
    rnd = 32'h296A9403;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    for (c = 0; c < 4; c++) begin
      b = 12'(c * 16);
      rd(b, 32'h0);
      rd(b + 12'h004, 32'h0);
      rnd = lf(rnd);
      w = rnd;
      apb(1'b1, b, w);
      apb(1'b1, b + 12'h004, w | 32'hFC00);
      rd(b, {16'h0, w[15:0]});
      rd(b + 12'h004, {22'h0, w[9:0]});
    end
    rd(12'h040, 32'h0);
    rd(12'h006, 32'h0);
    runCh(12'h000, 10'h000);
    runCh(12'h000, 10'h005);
    runCh(12'h030, 10'h3FF);
    tally_and_finish;
  end
endmodule // test_dma_channel_addr_count_regs
